/* sicr_pkg.sv */
// constants shared by the synthesizer config link ends
package sicr_pkg;
  // serial word layout
  localparam int WORD_W = 24;
  localparam int DATA_W = 20;
  localparam int ADDR_W = 4;
  localparam int NREG   = 6;
  // register slots: aux n, ifref, func, xfrac, fast, cntr
  localparam int SLOT_AUXN  = 0;
  localparam int SLOT_IFREF = 1;
  localparam int SLOT_FUNC  = 2;
  localparam int SLOT_XFRAC = 3;
  localparam int SLOT_FAST  = 4;
  localparam int SLOT_CNTR  = 5;
  localparam logic [3:0] SLOT_ADDR [NREG] =
    '{4'h5, 4'h7, 4'h9, 4'hB, 4'hD, 4'hF};
  localparam logic [19:0] SLOT_RESET [NREG] =
    '{20'h00000, 20'h10003, 20'h22C70, 20'h00000, 20'h00000, 20'h00090};
  // optional register defaults
  localparam logic [19:0] XFRAC_DEF  = 20'h00000;
  localparam logic [19:0] FAST_DEF   = 20'h00000;
  localparam logic [19:0] CNTR_DEF   = 20'h00090;
  localparam logic [19:0] FUNC_TYPICAL = 20'h22C70;
  // data field positions (word bit minus four)
  localparam int AUXN_PD_BIT = 19;
  localparam int IFR_LSB  = 0;
  localparam int GAIN_LSB = 12;
  localparam int ACC_LSB  = 16;
  localparam int AUTO_POWERUP_ENABLE_BIT = 19;
  localparam int DITHER_SELECT_LSB = 12;
  localparam int FM_LSB   = 10;
  localparam int DBL_BIT  = 8;
  localparam int OSCO_BIT = 7;
  localparam int IFCPP_BIT = 6;
  localparam int RFCPP_BIT = 5;
  localparam int IFP_BIT  = 4;
  localparam int MUX_LSB  = 0;
  localparam logic [11:0] IFR_MIN   = 12'h003;
  localparam logic [14:0] IFNB_MIN  = 15'h0003;
  localparam logic [14:0] IFNB_FREE = 15'h000F;
  localparam int CPG_STEP_UA = 95;
  localparam logic AUX_PD_RESET = 1'b1;
  // link timing
  localparam int CLK_NS       = 10;
  localparam int LINK_HALF_NS = 80;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // host register map
  localparam int AXI_AW = 8;
  localparam logic [7:0] A_WORD = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {
    SICR_IDLE  = 2'b00,
    SICR_LOW   = 2'b01,
    SICR_HIGH  = 2'b10,
    SICR_LATCH = 2'b11
  } sicr_st_t;
endpackage

/* sicr_link_if.sv */
// three-wire link plus chip enable between host and device
`timescale 1ns/1ps
interface sicr_link_if;
  logic link_clk;
  logic link_data;
  logic link_latch;
  logic chip_en;
  modport host (output link_clk, output link_data,
                output link_latch, output chip_en);
  modport device (input link_clk, input link_data,
                  input link_latch, input chip_en);
endinterface

/* sicr_sync.sv */
// two-flop synchroniser for a bundle of slow pins
`timescale 1ns/1ps
module sicr_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] synced
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      synced   <= '0;
    end else begin
      meta_reg <= pins;
      synced   <= meta_reg;
    end
  end
endmodule

/* sicr_device.sv */
// device end: serial shifter, config registers, power control
`timescale 1ns/1ps
module sicr_device (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // serial link
  sicr_link_if.device      link,
  // power state and latch strobe
  output logic             AUX_PLL_ON,
  output logic             AUX_PUMP_TRISTATE,
  output logic             WORD_LATCHED,
  // dividers, pump gain and access enables
  output logic [18:0]      AUX_N_DIV,
  output logic [11:0]      AUX_R_DIV,
  output logic [3:0]       MAIN_PUMP_GAIN,
  output logic [10:0]      MAIN_PUMP_UA,
  output logic [3:0]       ACCESS_EN,
  // function word fields
  output logic             AUTO_POWERUP_ENABLE,
  output logic [1:0]       DITHER_SELECT,
  output logic [1:0]       MODULATOR_ORDER,
  output logic             REF_DOUBLER_ENABLE,
  output logic             REF_BUFFER_OUT_ENABLE,
  output logic             AUX_PUMP_POLARITY,
  output logic             MAIN_PUMP_POLARITY,
  output logic             AUX_PRESCALER_SEL,
  output logic [3:0]       TEST_LOCK_OUT_SELECT,
  // effective optional words
  output logic [19:0]      XFRAC_WORD,
  output logic [19:0]      FAST_WORD,
  output logic [19:0]      CNTR_WORD
);
  logic [3:0]  pin_s;
  logic        clk_d;
  logic        latch_d;
  logic [23:0] shift_reg;
  logic        aux_pd_reg;
  logic [19:0] cfg_reg [sicr_pkg::NREG];

  // link pins are asynchronous; only the second flop is read
  sicr_sync #(
    .W (4)
  ) u_sync (
    .clk   (CLK),
    .rst   (RST),
    .pins   ({link.link_clk, link.link_data,
              link.link_latch, link.chip_en}),
    .synced (pin_s)
  );

  wire sclk   = pin_s[3];
  wire sdata  = pin_s[2];
  wire slatch = pin_s[1];
  wire sce    = pin_s[0];

  wire clk_rise   = sclk & ~clk_d;
  wire latch_rise = slatch & ~latch_d;
  wire [3:0]  addr = shift_reg[3:0];
  wire [19:0] data = shift_reg[23:4];
  // any address with bit 0 clear is the frequency word
  wire freq_hit = latch_rise & ~addr[0];
  wire auxn_hit = latch_rise &
                  (addr == sicr_pkg::SLOT_ADDR[sicr_pkg::SLOT_AUXN]);

  // decoded fields of the stored words
  wire [19:0] ifref = cfg_reg[sicr_pkg::SLOT_IFREF];
  wire [19:0] func  = cfg_reg[sicr_pkg::SLOT_FUNC];
  wire [3:0]  acc   = ifref[sicr_pkg::ACC_LSB +: 4];
  wire [3:0]  gain  = ifref[sicr_pkg::GAIN_LSB +: 4];
  wire        auto_powerup_enable  = func[sicr_pkg::AUTO_POWERUP_ENABLE_BIT];
  // chip enable low outranks both the bit and auto powerup
  wire        pll_on = sce & ~aux_pd_reg;

  // edge memories for the synchronised pins
  always_ff @(posedge CLK) begin
    if (RST) begin
      clk_d   <= 1'b0;
      latch_d <= 1'b0;
    end else begin
      clk_d   <= sclk;
      latch_d <= slatch;
    end
  end

  // msb arrives first, so it ends at bit 23
  always_ff @(posedge CLK) begin
    if (RST) begin
      shift_reg <= 24'h000000;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[22:0], sdata};
    end
  end

  // one slot per odd address from 5 to F, none for the frequency word; only the data field is kept
  for (genvar i = 0; i < sicr_pkg::NREG; i++) begin : g_slot
    always_ff @(posedge CLK) begin
      if (RST) begin
        cfg_reg[i] <= sicr_pkg::SLOT_RESET[i];
      end else if (latch_rise && addr == sicr_pkg::SLOT_ADDR[i]) begin
        cfg_reg[i] <= data;
      end
    end
  end

  // auto powerup is held off while chip enable is low
  always_ff @(posedge CLK) begin
    if (RST) begin
      aux_pd_reg <= sicr_pkg::AUX_PD_RESET;
    end else if (freq_hit && auto_powerup_enable && sce) begin
      aux_pd_reg <= 1'b0;
    end else if (auxn_hit) begin
      aux_pd_reg <= data[sicr_pkg::AUXN_PD_BIT];
    end
  end

  // pump goes hi-z whenever the aux pll is off
  always_ff @(posedge CLK) begin
    if (RST) begin
      AUX_PLL_ON        <= 1'b0;
      AUX_PUMP_TRISTATE <= 1'b1;
      WORD_LATCHED      <= 1'b0;
    end else begin
      AUX_PLL_ON        <= pll_on;
      AUX_PUMP_TRISTATE <= ~pll_on;
      WORD_LATCHED      <= latch_rise;
    end
  end

  // divider ratio equals the field, no offset
  always_ff @(posedge CLK) begin
    if (RST) begin
      AUX_N_DIV      <= 19'h00000;
      AUX_R_DIV      <= 12'h000;
      MAIN_PUMP_GAIN <= 4'h0;
      MAIN_PUMP_UA   <= 11'h000;
      ACCESS_EN      <= 4'h0;
    end else begin
      AUX_N_DIV      <= cfg_reg[sicr_pkg::SLOT_AUXN][18:0];
      AUX_R_DIV      <= ifref[sicr_pkg::IFR_LSB +: 12];
      MAIN_PUMP_GAIN <= gain;
      MAIN_PUMP_UA   <= 11'((11'(gain) + 11'h001) *
                            11'(sicr_pkg::CPG_STEP_UA));
      ACCESS_EN      <= acc;
    end
  end

  // function word has no forced default; the reset value is typical
  always_ff @(posedge CLK) begin
    if (RST) begin
      AUTO_POWERUP_ENABLE   <= 1'b0;
      DITHER_SELECT         <= 2'h0;
      MODULATOR_ORDER       <= 2'h0;
      REF_DOUBLER_ENABLE    <= 1'b0;
      REF_BUFFER_OUT_ENABLE <= 1'b0;
      AUX_PUMP_POLARITY     <= 1'b0;
      MAIN_PUMP_POLARITY    <= 1'b0;
      AUX_PRESCALER_SEL     <= 1'b0;
      TEST_LOCK_OUT_SELECT  <= 4'h0;
    end else begin
      AUTO_POWERUP_ENABLE   <= auto_powerup_enable;
      DITHER_SELECT         <= func[sicr_pkg::DITHER_SELECT_LSB +: 2];
      MODULATOR_ORDER       <= func[sicr_pkg::FM_LSB +: 2];
      REF_DOUBLER_ENABLE    <= func[sicr_pkg::DBL_BIT];
      REF_BUFFER_OUT_ENABLE <= func[sicr_pkg::OSCO_BIT];
      AUX_PUMP_POLARITY     <= func[sicr_pkg::IFCPP_BIT];
      MAIN_PUMP_POLARITY    <= func[sicr_pkg::RFCPP_BIT];
      AUX_PRESCALER_SEL     <= func[sicr_pkg::IFP_BIT];
      TEST_LOCK_OUT_SELECT  <= func[sicr_pkg::MUX_LSB +: 4];
    end
  end

  // stored contents survive while forced, so re-enabling restores them
  always_ff @(posedge CLK) begin
    if (RST) begin
      XFRAC_WORD <= sicr_pkg::XFRAC_DEF;
      FAST_WORD  <= sicr_pkg::FAST_DEF;
      CNTR_WORD  <= sicr_pkg::CNTR_DEF;
    end else begin
      XFRAC_WORD <= acc[1] ? cfg_reg[sicr_pkg::SLOT_XFRAC]
                           : sicr_pkg::XFRAC_DEF;
      FAST_WORD  <= acc[2] ? cfg_reg[sicr_pkg::SLOT_FAST]
                           : sicr_pkg::FAST_DEF;
      CNTR_WORD  <= acc[3] ? cfg_reg[sicr_pkg::SLOT_CNTR]
                           : sicr_pkg::CNTR_DEF;
    end
  end
endmodule

/* sicr_host.sv */
// host end: axi4-lite registers driving the serial link
`timescale 1ns/1ps
module sicr_host (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // axi4-lite write
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // serial link
  sicr_link_if.host        link
);
  sicr_pkg::sicr_st_t st_reg;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [3:0]  div_cnt;
  logic [4:0]  bit_cnt;
  logic [23:0] tx_reg;
  logic        ce_reg;
  logic        refused_reg;
  logic        prescale16_reg;
  logic [7:0]  sent_mask;

  wire do_wr = aw_held & w_held & ~BVALID;
  wire busy  = (st_reg != sicr_pkg::SICR_IDLE);
  wire tick  = (div_cnt == 4'(sicr_pkg::LINK_HALF_CYC - 1));
  wire [23:0] word = w_data[23:0];
  wire [3:0]  waddr = word[3:0];
  wire [14:0] nb = word[22:8];
  wire [3:0]  na = word[7:4];
  // a partial write of the word register is not a legal word
  wire strb_full = (w_strb[2:0] == 3'h7);
  wire n_bad = prescale16_reg && (nb < sicr_pkg::IFNB_MIN ||
               (nb < sicr_pkg::IFNB_FREE && 15'(na) > nb));
  wire r_bad = (word[15:4] < sicr_pkg::IFR_MIN) | ~word[20];
  wire is_auxn  = (waddr == sicr_pkg::SLOT_ADDR[sicr_pkg::SLOT_AUXN]);
  wire is_ifref = (waddr == sicr_pkg::SLOT_ADDR[sicr_pkg::SLOT_IFREF]);
  wire word_bad = busy | ~strb_full | (is_auxn & n_bad) |
                  (is_ifref & r_bad);
  wire wr_word = do_wr && aw_addr == sicr_pkg::A_WORD;
  wire start   = wr_word & ~word_bad;

  // address and data are taken in either order
  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else if (do_wr) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= sicr_pkg::RESP_OK;
    end else begin
      AWREADY <= ~aw_held & ~(AWVALID & AWREADY) & ~do_wr;
      WREADY  <= ~w_held & ~(WVALID & WREADY) & ~do_wr;
      if (do_wr) begin
        BVALID <= 1'b1;
        BRESP  <= (aw_addr == sicr_pkg::A_WORD ||
                   aw_addr == sicr_pkg::A_CTRL ||
                   aw_addr == sicr_pkg::A_STAT) ? sicr_pkg::RESP_OK
                                                : sicr_pkg::RESP_ERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // status: refused flag is sticky, set wins over a write-one clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      ce_reg      <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (do_wr && aw_addr == sicr_pkg::A_CTRL && w_strb[0]) begin
        ce_reg <= w_data[0];
      end
      if (wr_word && word_bad) begin
        refused_reg <= 1'b1;
      end else if (do_wr && aw_addr == sicr_pkg::A_STAT &&
                   w_strb[0] && w_data[1]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // first four words are mandatory; mask shows which went out
  always_ff @(posedge CLK) begin
    if (RST) begin
      sent_mask      <= 8'h00;
      prescale16_reg <= sicr_pkg::FUNC_TYPICAL[sicr_pkg::IFP_BIT];
    end else if (start) begin
      sent_mask[waddr[0] ? waddr[3:1] : 3'h0] <= 1'b1;
      if (waddr == sicr_pkg::SLOT_ADDR[sicr_pkg::SLOT_FUNC]) begin
        prescale16_reg <= word[4 + sicr_pkg::IFP_BIT];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= sicr_pkg::RESP_OK;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RRESP   <= sicr_pkg::RESP_OK;
      unique case (ARADDR)
        sicr_pkg::A_WORD: RDATA <= {8'h00, tx_reg};
        sicr_pkg::A_CTRL: RDATA <= {31'h00000000, ce_reg};
        sicr_pkg::A_STAT:
          RDATA <= {16'h0000, sent_mask, 6'h00, refused_reg, busy};
        default: begin
          RDATA <= 32'h00000000;
          RRESP <= sicr_pkg::RESP_ERR;
        end
      endcase
    end else if (RVALID) begin
      if (RREADY) begin
        RVALID <= 1'b0;
      end
    end else begin
      ARREADY <= 1'b1;
    end
  end

  // half-period enable for the link clock
  always_ff @(posedge CLK) begin
    if (RST || start) begin
      div_cnt <= 4'h0;
    end else if (tick) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // data changes on the falling edge, device samples on the rise
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg          <= sicr_pkg::SICR_IDLE;
      tx_reg          <= 24'h000000;
      bit_cnt         <= 5'h00;
      link.link_clk   <= 1'b0;
      link.link_data  <= 1'b0;
      link.link_latch <= 1'b0;
    end else begin
      unique case (st_reg)
        sicr_pkg::SICR_IDLE: if (start) begin
          tx_reg         <= word;
          link.link_data <= word[23];
          bit_cnt        <= 5'h00;
          st_reg         <= sicr_pkg::SICR_LOW;
        end
        sicr_pkg::SICR_LOW: if (tick) begin
          link.link_clk <= 1'b1;
          st_reg        <= sicr_pkg::SICR_HIGH;
        end
        sicr_pkg::SICR_HIGH: if (tick) begin
          link.link_clk <= 1'b0;
          bit_cnt       <= bit_cnt + 5'h01;
          if (bit_cnt == 5'(sicr_pkg::WORD_W - 1)) begin
            link.link_latch <= 1'b1;
            st_reg          <= sicr_pkg::SICR_LATCH;
          end else begin
            tx_reg         <= {tx_reg[22:0], 1'b0};
            link.link_data <= tx_reg[22];
            st_reg         <= sicr_pkg::SICR_LOW;
          end
        end
        sicr_pkg::SICR_LATCH: if (tick) begin
          link.link_latch <= 1'b0;
          st_reg          <= sicr_pkg::SICR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      link.chip_en <= 1'b0;
    end else begin
      link.chip_en <= ce_reg;
    end
  end
endmodule

/* sicr_link_props.sv */
// timing checks on the three-wire link between the two ends
`timescale 1ns/1ps
module sicr_link_props (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // link pins
  input  wire logic link_clk,
  input  wire logic link_data,
  input  wire logic link_latch,
  input  wire logic chip_en
);
  logic [4:0] bits_reg;
  logic [4:0] low_reg;
  logic       clk_d_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  always_ff @(posedge CLK) begin
    clk_d_reg <= RST ? 1'b0 : link_clk;
  end

  // bits in the current frame, cleared once the latch shows
  always_ff @(posedge CLK) begin
    if (RST || link_latch) begin
      bits_reg <= 5'h00;
    end else if (link_clk && !clk_d_reg) begin
      bits_reg <= bits_reg + 5'h01;
    end
  end

  // saturating count of low cycles before each rise
  always_ff @(posedge CLK) begin
    if (RST || link_clk) begin
      low_reg <= 5'h00;
    end else if (low_reg != 5'h1F) begin
      low_reg <= low_reg + 5'h01;
    end
  end

  AST_LATCH_WIDTH: assert property (
    $rose(link_latch) |=> link_latch [*7] ##1 !link_latch)
    else $error("latch strobe not eight cycles");
  AST_CLK_HIGH: assert property (
    $rose(link_clk) |=> link_clk [*7] ##1 !link_clk)
    else $error("link clock high phase wrong");
  AST_CLK_LOW: assert property (
    $rose(link_clk) |-> low_reg >= 5'h08)
    else $error("link clock low phase too short");
  AST_BIT_COUNT: assert property (
    $rose(link_latch) |-> bits_reg == 5'h18)
    else $error("latch after wrong bit count");
  AST_DATA_HOLD: assert property (
    link_clk && clk_d_reg |-> $stable(link_data))
    else $error("data moved while clock high");
  AST_LATCH_CLK_LOW: assert property (
    link_latch |-> !link_clk)
    else $error("clock high during latch");
  AST_BITS_MAX: assert property (
    bits_reg <= 5'h18)
    else $error("more than 24 bits in a frame");
  AST_LATCH_FOLLOWS: assert property (
    $fell(link_clk) && bits_reg == 5'h18 |-> ##[0:16] link_latch)
    else $error("no latch after last bit");

  cover property ($rose(link_latch));
  cover property ($rose(chip_en));
  cover property ($fell(chip_en));
endmodule

/* tb_synth_if_config_regs.sv */
// self-checking bench: host and device ends joined by the link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; \
  if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_synth_if_config_regs;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic AUX_PLL_ON, AUX_PUMP_TRISTATE, WORD_LATCHED, AUTO_POWERUP_ENABLE;
  logic REF_DOUBLER_ENABLE, REF_BUFFER_OUT_ENABLE, AUX_PRESCALER_SEL;
  logic AUX_PUMP_POLARITY, MAIN_PUMP_POLARITY;
  logic [18:0] AUX_N_DIV;
  logic [11:0] AUX_R_DIV;
  logic [3:0] MAIN_PUMP_GAIN, ACCESS_EN, TEST_LOCK_OUT_SELECT;
  logic [10:0] MAIN_PUMP_UA;
  logic [1:0] DITHER_SELECT, MODULATOR_ORDER;
  logic [19:0] XFRAC_WORD, FAST_WORD, CNTR_WORD;
  logic [125:0] dev_snap, e_snap;
  logic [19:0] auxn_m, ifr_m, fn_m, xf_m, fa_m, cn_m;
  logic pd_m, ce_m, late;
  logic [7:0] mask_m;
  logic [2:0] acc;
  logic [11:0] r;
  logic [33:0] e_rd;
  logic [1:0] e_b;
  logic [125:0] dev_q[$];
  logic [33:0] rd_q[$];
  logic [1:0] b_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int k;

  always #5 CLK = ~CLK;

  sicr_link_if i_sicr_link_if ();
  sicr_host i_sicr_host (.CLK(CLK), .RST(RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .link(i_sicr_link_if));
  sicr_device i_sicr_device (.CLK(CLK), .RST(RST), .link(i_sicr_link_if),
    .AUX_PLL_ON(AUX_PLL_ON), .AUX_PUMP_TRISTATE(AUX_PUMP_TRISTATE),
    .WORD_LATCHED(WORD_LATCHED), .AUX_N_DIV(AUX_N_DIV),
    .AUX_R_DIV(AUX_R_DIV), .MAIN_PUMP_GAIN(MAIN_PUMP_GAIN),
    .MAIN_PUMP_UA(MAIN_PUMP_UA), .ACCESS_EN(ACCESS_EN),
    .AUTO_POWERUP_ENABLE(AUTO_POWERUP_ENABLE),
    .DITHER_SELECT(DITHER_SELECT), .MODULATOR_ORDER(MODULATOR_ORDER),
    .REF_DOUBLER_ENABLE(REF_DOUBLER_ENABLE),
    .REF_BUFFER_OUT_ENABLE(REF_BUFFER_OUT_ENABLE),
    .AUX_PUMP_POLARITY(AUX_PUMP_POLARITY),
    .MAIN_PUMP_POLARITY(MAIN_PUMP_POLARITY),
    .AUX_PRESCALER_SEL(AUX_PRESCALER_SEL),
    .TEST_LOCK_OUT_SELECT(TEST_LOCK_OUT_SELECT),
    .XFRAC_WORD(XFRAC_WORD), .FAST_WORD(FAST_WORD), .CNTR_WORD(CNTR_WORD));
  sicr_link_props i_sicr_link_props (.CLK(CLK), .RST(RST),
    .link_clk(i_sicr_link_if.link_clk), .link_data(i_sicr_link_if.link_data),
    .link_latch(i_sicr_link_if.link_latch),
    .chip_en(i_sicr_link_if.chip_en));

  assign dev_snap = {AUX_PLL_ON, AUX_PUMP_TRISTATE, AUX_N_DIV, AUX_R_DIV,
    MAIN_PUMP_GAIN, MAIN_PUMP_UA, ACCESS_EN, AUTO_POWERUP_ENABLE,
    DITHER_SELECT, MODULATOR_ORDER, REF_DOUBLER_ENABLE,
    REF_BUFFER_OUT_ENABLE, AUX_PUMP_POLARITY, MAIN_PUMP_POLARITY,
    AUX_PRESCALER_SEL, TEST_LOCK_OUT_SELECT, XFRAC_WORD, FAST_WORD,
    CNTR_WORD};

  // expected device outputs from the shadow of every word sent
  function automatic logic [125:0] exp_snap();
    logic on;
    on = ce_m & ~pd_m;
    return {on, ~on, auxn_m[18:0], ifr_m[11:0], ifr_m[15:12],
      11'((ifr_m[15:12] + 11'h001) * 11'h05F), ifr_m[19:16], fn_m[19],
      fn_m[13:12], fn_m[11:10], fn_m[8:4], fn_m[3:0],
      ifr_m[17] ? xf_m : 20'h00000, ifr_m[18] ? fa_m : 20'h00000,
      ifr_m[19] ? cn_m : 20'h00090};
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] rsp);
    logic aw_p, w_p, b_p;
    @(posedge CLK);
    b_q.push_back(rsp);
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (aw_p || w_p || b_p) begin
      @(posedge CLK);
      if (aw_p && AWREADY === 1'b1) begin AWVALID <= 1'b0; aw_p = 1'b0; end
      if (w_p && WREADY === 1'b1) begin WVALID <= 1'b0; w_p = 1'b0; end
      if (b_p && BVALID === 1'b1) begin BREADY <= 1'b0; b_p = 1'b0; end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
    logic ar_p, r_p;
    @(posedge CLK);
    rd_q.push_back(e);
    ar_p = 1'b1;
    r_p = 1'b1;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (ar_p || r_p) begin
      @(posedge CLK);
      if (ar_p && ARREADY === 1'b1) begin ARVALID <= 1'b0; ar_p = 1'b0; end
      if (r_p && RVALID === 1'b1) begin RREADY <= 1'b0; r_p = 1'b0; end
    end
  endtask

  // shadow update first, so the note matches what the device must show
  task automatic send(input logic [3:0] a, input logic [19:0] d);
    int n;
    case (a)
      4'h5: begin auxn_m = d; pd_m = d[19]; end
      4'h7: ifr_m = d;
      4'h9: fn_m = d;
      4'hB: xf_m = d;
      4'hD: fa_m = d;
      4'hF: cn_m = d;
      default: if (fn_m[19] && ce_m) pd_m = 1'b0;
    endcase
    if (a[0]) mask_m[a[3:1]] = 1'b1;
    else mask_m[0] = 1'b1;
    dev_q.push_back(exp_snap());
    axi_write(sicr_pkg::A_WORD, {8'h00, d, a}, sicr_pkg::RESP_OK);
    n = 0;
    while (WORD_LATCHED !== 1'b1 && n < 800) begin @(posedge CLK); n++; end
    repeat (12) @(posedge CLK);
  endtask

  // a refused word must leave the link quiet and flag it in status
  task automatic refuse(input logic [3:0] a, input logic [19:0] d);
    axi_write(sicr_pkg::A_WORD, {8'h00, d, a}, sicr_pkg::RESP_OK);
    axi_read(sicr_pkg::A_STAT, {18'h00000, mask_m, 8'h02});
    axi_write(sicr_pkg::A_STAT, 32'h00000002, sicr_pkg::RESP_OK);
    axi_read(sicr_pkg::A_STAT, {18'h00000, mask_m, 8'h00});
  endtask

  task automatic final_report();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // results compared one negedge after the latch pulse, once settled
  always @(negedge CLK) begin
    if (late) begin
      e_snap = dev_q.size() > 0 ? dev_q.pop_front() : 'x;
      `CHK("power", e_snap[125:124], dev_snap[125:124])
      `CHK("aux_n", e_snap[123:105], dev_snap[123:105])
      `CHK("ifref", e_snap[104:74], dev_snap[104:74])
      `CHK("func", e_snap[73:60], dev_snap[73:60])
      `CHK("optional", e_snap[59:0], dev_snap[59:0])
    end
    late = (WORD_LATCHED === 1'b1);
    if (RVALID === 1'b1 && RREADY === 1'b1) begin
      e_rd = rd_q.size() > 0 ? rd_q.pop_front() : 'x;
      `CHK("read", e_rd, {RRESP, RDATA})
    end
    if (BVALID === 1'b1 && BREADY === 1'b1) begin
      e_b = b_q.size() > 0 ? b_q.pop_front() : 'x;
      `CHK("bresp", e_b, BRESP)
    end
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    late = 1'b0;
    {auxn_m, xf_m, fa_m, ce_m, mask_m} = 69'h0;
    {pd_m, ifr_m, fn_m, cn_m} = {1'b1, 20'h10003, 20'h22C70, 20'h00090};
    void'($urandom(45));
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    repeat (3) @(posedge CLK);
    axi_read(sicr_pkg::A_STAT, 34'h0);
    axi_write(8'h10, 32'h0, sicr_pkg::RESP_ERR);
    axi_read(8'h0C, {sicr_pkg::RESP_ERR, 32'h0});
    axi_write(sicr_pkg::A_CTRL, 32'h1, sicr_pkg::RESP_OK);
    ce_m = 1'b1;
    axi_read(sicr_pkg::A_CTRL, 34'h1);
    send(4'h7, 20'h10003);
    send(4'h9, 20'hA2C70);
    send(4'h5, {1'b1, 19'(240 + $urandom_range(0, 5000))});
    send(4'h0, 20'h12345);
    // every gain code, ratio at both ends of its range
    for (k = 0; k < 16; k++) begin
      acc = 3'($urandom_range(0, 7));
      r = k == 0 ? 12'h003 : k == 15 ? 12'hFFF : 12'($urandom_range(3, 4095));
      send(4'h7, {acc, 1'b1, 4'(k), r});
      send(4'hB + 4'(2 * (k % 3)), 20'($urandom));
    end
    refuse(4'h7, 20'h10002);
    refuse(4'h7, 20'h00005);
    refuse(4'h5, 20'h0002F);
    refuse(4'h5, 20'h00034);
    send(4'h5, 20'h00033);
    axi_write(sicr_pkg::A_CTRL, 32'h0, sicr_pkg::RESP_OK);
    ce_m = 1'b0;
    send(4'h5, 20'h000F0);
    axi_write(sicr_pkg::A_CTRL, 32'h1, sicr_pkg::RESP_OK);
    ce_m = 1'b1;
    send(4'h9, 20'h22C60);
    send(4'h5, 20'h80018);
    send(4'h0, 20'h00000);
    axi_read(sicr_pkg::A_STAT, {18'h00000, mask_m, 8'h00});
    repeat (20) @(posedge CLK);
    `CHK("queues", 0, dev_q.size() + rd_q.size() + b_q.size())
    final_report();
  end
endmodule
